// File: verilog/mrc_pkg.sv
// Package of register offsets, fields, reset values and timing for the mesh radio config bank.
package mrc_pkg;
	// --------------------------------------------------------------------
	// Register byte offsets
	// --------------------------------------------------------------------
	localparam logic [7:0] ADDR_BYTE_COUNT_IDX = 8'h01;
	localparam logic [7:0] OFF_ADDR_BYTE_COUNT = 8'h04;
	localparam logic [7:0] OFF_DEV_ADDR_LO     = 8'h08;
	localparam logic [7:0] OFF_DEV_ADDR_HI     = 8'h0C;
	localparam logic [7:0] OFF_NET_TIMING      = 8'h10;
	localparam logic [7:0] OFF_NETWORK_IDENT   = 8'h14;
	localparam logic [7:0] OFF_HOP_SEQ_SEL     = 8'h18;
	localparam logic [7:0] OFF_TX_LEVEL_SEL    = 8'h1C;
	localparam logic [7:0] OFF_SERIAL_BAUD_SEL = 8'h20;
	localparam logic [7:0] OFF_ROLE_SEL        = 8'h24;
	localparam logic [7:0] OFF_IDLE_CLOCK_SEL  = 8'h28;
	localparam logic [7:0] OFF_EXT_SLP_ADDR    = 8'h2C;
	localparam logic [7:0] OFF_EXT_SLP_DRIFT   = 8'h30;
	localparam logic [7:0] OFF_RADIO_RATE      = 8'h34;
	localparam logic [7:0] OFF_KEY_LOW_LO      = 8'h38;
	localparam logic [7:0] OFF_KEY_LOW_HI      = 8'h3C;
	localparam logic [7:0] OFF_KEY_HIGH_LO     = 8'h40;
	localparam logic [7:0] OFF_KEY_HIGH_HI     = 8'h44;
	localparam logic [7:0] OFF_TWO_WIRE_CFG    = 8'h48;
	localparam logic [7:0] OFF_AUX_SETTLE_MS   = 8'h4C;
	localparam logic [7:0] OFF_PEND_TIMING     = 8'h50;
	localparam logic [7:0] OFF_STATUS          = 8'h54;

	// --------------------------------------------------------------------
	// Limits and reset values
	// --------------------------------------------------------------------
	localparam logic [7:0] NET_IDENT_MAX       = 8'h07;
	localparam logic [7:0] HOP_SEQ_MAX         = 8'h05;
	localparam logic [7:0] ADDR_BYTES_MAX      = 8'h08;
	localparam logic [7:0] EXT_SLP_ADDR_RST    = 8'h48;
	localparam logic [7:0] RADIO_RATE_RST      = 8'h00;
	localparam logic [7:0] ADDR_BYTE_COUNT_RST = 8'h08;
	localparam logic [7:0] DRIFT_CORR_RST      = 8'h00;
	localparam logic [7:0] PAYLOAD_MAX_50K     = 8'h14;
	localparam logic [7:0] PAYLOAD_MAX_100K    = 8'h48;

	// --------------------------------------------------------------------
	// Two-wire config field positions
	// --------------------------------------------------------------------
	localparam int TW_BIT_PERIOD_LSB = 0;
	localparam int TW_PORT_SEL_BIT   = 4;
	localparam int TW_PULLUP_BIT     = 5;
	localparam int TW_AUX_MODE_LSB   = 6;

	// --------------------------------------------------------------------
	// Timing
	// --------------------------------------------------------------------
	localparam int CLK_HZ       = 200000000;
	localparam int MS_PER_S     = 1000;
	localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;

	// --------------------------------------------------------------------
	// Enumerations
	// --------------------------------------------------------------------
	typedef enum logic [1:0] {
		AUX_HIZ,
		AUX_SWITCHED,
		AUX_GROUND,
		AUX_SUPPLY
	} mrc_aux_mode_t;

	typedef enum logic [1:0] {
		CLK_FAST,
		CLK_RC,
		CLK_EXT,
		CLK_RSVD
	} mrc_idle_clk_t;
endpackage

// File: verilog/mrc_aux_if.sv
// Interface carrying the auxiliary power pin request between the bank and its sequencer.
`timescale 1ns/10ps
interface mrc_aux_if;
	logic       req;
	logic       done;
	logic [1:0] mode;
	logic [7:0] settle_ms;
	logic       bus_go;
	logic       pin_o;
	logic       pin_oe;
	modport bank (output req, done, mode, settle_ms, input bus_go, pin_o, pin_oe);
	modport seq  (input req, done, mode, settle_ms, output bus_go, pin_o, pin_oe);
endinterface

// File: verilog/mrc_aux_seq.sv
// Auxiliary power pin sequencer with settle delay before two-wire bus activity.
`timescale 1ns/10ps
module mrc_aux_seq
	import mrc_pkg::*;
#(
	parameter int CYC_MS = CYCLES_PER_MS
) (
	// Clock and reset.
	input  wire logic clk,
	input  wire logic arst_n,
	// Link to the bank.
	mrc_aux_if.seq    aux
);
	typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_BUSY} mrc_seq_t;

	mrc_seq_t    state_q;
	logic [31:0] cyc_q;
	logic [7:0]  ms_q;
	logic        ms_tick;
	logic        settled;
	logic        switched;

	// --------------------------------------------------------------------
	// Millisecond enable and settle test
	// --------------------------------------------------------------------
	assign ms_tick  = (cyc_q == 32'(CYC_MS - 1));
	assign settled  = (ms_q >= aux.settle_ms);
	assign switched = (aux.mode == AUX_SWITCHED);

	// Pin drive follows the mode; switched mode drives supply only around a transaction.
	assign aux.pin_oe = (aux.mode == AUX_GROUND) || (aux.mode == AUX_SUPPLY) ||
		(switched && state_q != S_IDLE);
	assign aux.pin_o  = (aux.mode != AUX_GROUND);
	assign aux.bus_go = (state_q == S_BUSY) ||
		(!switched && aux.req);

	// Sequencer: power up, wait settle_ms, run the bus, release on done.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= S_IDLE;
			cyc_q   <= 32'h0;
			ms_q    <= 8'h00;
		end else begin
			unique case (state_q)
				S_IDLE: begin
					cyc_q <= 32'h0;
					ms_q  <= 8'h00;
					if (aux.req && switched) begin
						state_q <= S_SETTLE;
					end
				end
				S_SETTLE: begin
					cyc_q <= ms_tick ? 32'h0 : cyc_q + 32'h1;
					if (ms_tick) begin
						ms_q <= ms_q + 8'h01;
					end
					if (settled) begin
						state_q <= S_BUSY;
					end
				end
				S_BUSY: begin
					if (aux.done) begin
						state_q <= S_IDLE;
					end
				end
				// The fourth code of the state word is never entered; recover to idle.
				default: state_q <= S_IDLE;
			endcase
		end
	end
endmodule // mrc_aux_seq

// File: verilog/mrc_config_regs.sv
// Configuration register bank of the mesh radio transceiver, reached over APB.
//
// What this block does
// - Device address held as eight bytes, LSB first.
// - Effective address uses addr_byte_count low bytes.
// - Timing register read-only; update at cycle start.
// - Network identifier accepts zero through seven.
// - Drop packets with foreign network identifier.
// - Hop sequence selector accepts zero through five.
// - Transmit level one high, zero low power.
// - Role zero gateway, one mesh node.
// - Idle clock fast, RC, or external controller.
// - RC mode recalibrates every broadcast cycle unless rc_cal_done is high.
// - External controller address defaults 0x48, used.
// - Drift correction factor readable, read-only.
// - Preset zero default: 50 kbit/s, 20 bytes.
// - Preset one: 100 kbit/s, 72 bytes.
// - Low key holds key bytes zero to seven.
// - Bit period parameter drives two-wire speed.
// - Weak pull-up enable drives port pull-ups.
// - Aux pin: hi-Z, switched, ground, supply.
// - Switched mode powers pin per transaction.
// - Switched mode waits settle milliseconds before bus activity.
`timescale 1ns/10ps
module mrc_config_regs
	import mrc_pkg::*;
#(
	parameter int CYC_MS = CYCLES_PER_MS
) (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        arst_n,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Radio core events and status.
	input  wire logic        cycle_start,
	input  wire logic        timing_sched,
	input  wire logic [7:0]  drift_corr_in,
	input  wire logic        rc_cal_done,
	// Received packet access key.
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_net_ident,
	input  wire logic [7:0]  rx_hop_seq,
	input  wire logic        rx_key_ok,
	output logic             rx_accept,
	// Configuration out to the radio.
	output logic      [63:0] eff_addr,
	output logic      [7:0]  net_timing,
	output logic      [7:0]  hop_seq,
	output logic      [7:0]  net_ident,
	output logic      [127:0] cipher_key,
	output logic             tx_high_power,
	output logic             role_node,
	output logic      [7:0]  baud_sel,
	output logic      [1:0]  idle_clk,
	output logic             rc_cal_req,
	output logic      [7:0]  ext_ctrl_addr,
	output logic             rate_100k,
	output logic      [7:0]  payload_max,
	// Two-wire port control.
	output logic      [3:0]  bit_period,
	output logic             port_sel,
	output logic             pullup_en,
	input  wire logic        ext_txn_req,
	input  wire logic        ext_txn_done,
	output logic             bus_go,
	output logic             aux_pin_o,
	output logic             aux_pin_oe
);
	// --------------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------------
	logic [63:0]  dev_addr_q;
	logic [7:0]   byte_count_q;
	logic [7:0]   timing_q;
	logic [7:0]   pend_timing_q;
	logic         pend_valid_q;
	logic [7:0]   ident_q;
	logic [7:0]   hop_q;
	logic [7:0]   tx_level_q;
	logic [7:0]   baud_q;
	logic [7:0]   role_q;
	logic [7:0]   idle_clk_q;
	logic [7:0]   ext_addr_q;
	logic [7:0]   drift_q;
	logic [7:0]   rate_q;
	logic [127:0] key_q;
	logic [7:0]   tw_cfg_q;
	logic [7:0]   settle_ms_q;
	logic         rx_drop_q;
	logic         rx_accept_q;

	// --------------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------------
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	logic [31:0] wmask;
	logic [31:0] rdata;

	// Strobes mask write lanes; every access completes in the access cycle.
	assign wr_en   = psel && penable && pwrite;
	assign rd_en   = psel && penable && !pwrite;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign wmask   = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

	// Merge masked write data into an old word.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	// Byte write helper used by all byte-wide registers.
	function automatic logic [7:0] wbyte(input logic [7:0] old, input logic [31:0] nw,
			input logic [31:0] m);
		logic [31:0] r;
		r = merge({24'h0, old}, nw, m);
		wbyte = r[7:0];
	endfunction

	logic [7:0] byte_count_w;
	logic [7:0] ident_w;
	logic [7:0] hop_w;

	assign byte_count_w = wbyte(byte_count_q, pwdata, wmask);
	assign ident_w      = wbyte(ident_q, pwdata, wmask);
	assign hop_w        = wbyte(hop_q, pwdata, wmask);

	// Read mux; reserved upper bits read zero.
	always_comb begin
		hit   = 1'b1;
		rdata = 32'h0;
		unique case (paddr)
			OFF_ADDR_BYTE_COUNT: rdata = {24'h0, byte_count_q};
			OFF_DEV_ADDR_LO:     rdata = dev_addr_q[31:0];
			OFF_DEV_ADDR_HI:     rdata = dev_addr_q[63:32];
			OFF_NET_TIMING:      rdata = {24'h0, timing_q};
			OFF_NETWORK_IDENT:   rdata = {24'h0, ident_q};
			OFF_HOP_SEQ_SEL:     rdata = {24'h0, hop_q};
			OFF_TX_LEVEL_SEL:    rdata = {24'h0, tx_level_q};
			OFF_SERIAL_BAUD_SEL: rdata = {24'h0, baud_q};
			OFF_ROLE_SEL:        rdata = {24'h0, role_q};
			OFF_IDLE_CLOCK_SEL:  rdata = {24'h0, idle_clk_q};
			OFF_EXT_SLP_ADDR:    rdata = {24'h0, ext_addr_q};
			OFF_EXT_SLP_DRIFT:   rdata = {24'h0, drift_q};
			OFF_RADIO_RATE:      rdata = {24'h0, rate_q};
			OFF_KEY_LOW_LO:      rdata = key_q[31:0];
			OFF_KEY_LOW_HI:      rdata = key_q[63:32];
			OFF_KEY_HIGH_LO:     rdata = key_q[95:64];
			OFF_KEY_HIGH_HI:     rdata = key_q[127:96];
			OFF_TWO_WIRE_CFG:    rdata = {24'h0, tw_cfg_q};
			OFF_AUX_SETTLE_MS:   rdata = {24'h0, settle_ms_q};
			OFF_PEND_TIMING:     rdata = {24'h0, pend_timing_q};
			OFF_STATUS:          rdata = {29'h0, rx_drop_q, rx_accept_q, pend_valid_q};
			default:             hit   = 1'b0;
		endcase
	end

	// Read data is registered so it stands in a flip-flop for the master.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			prdata <= rdata;
		end
	end

	// --------------------------------------------------------------------
	// Address and key registers
	// --------------------------------------------------------------------
	// Out-of-range counts are refused so the effective address stays well formed.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			dev_addr_q   <= 64'h0;
			byte_count_q <= ADDR_BYTE_COUNT_RST;
			key_q        <= 128'h0;
		end else if (wr_en) begin
			if (paddr == OFF_DEV_ADDR_LO)
				dev_addr_q[31:0] <= merge(dev_addr_q[31:0], pwdata, wmask);
			if (paddr == OFF_DEV_ADDR_HI)
				dev_addr_q[63:32] <= merge(dev_addr_q[63:32], pwdata, wmask);
			if (paddr == OFF_ADDR_BYTE_COUNT && byte_count_w <= ADDR_BYTES_MAX)
				byte_count_q <= byte_count_w;
			if (paddr == OFF_KEY_LOW_LO)
				key_q[31:0] <= merge(key_q[31:0], pwdata, wmask);
			if (paddr == OFF_KEY_LOW_HI)
				key_q[63:32] <= merge(key_q[63:32], pwdata, wmask);
			if (paddr == OFF_KEY_HIGH_LO)
				key_q[95:64] <= merge(key_q[95:64], pwdata, wmask);
			if (paddr == OFF_KEY_HIGH_HI)
				key_q[127:96] <= merge(key_q[127:96], pwdata, wmask);
		end
	end

	// Effective address keeps only the low byte_count bytes.
	always_comb begin
		eff_addr = 64'h0;
		for (int i = 0; i < 8; i++) begin
			if (8'(i) < byte_count_q) begin
				eff_addr[i*8 +: 8] = dev_addr_q[i*8 +: 8];
			end
		end
	end

	// --------------------------------------------------------------------
	// Network selection registers
	// --------------------------------------------------------------------
	// Illegal identifier or hop values are dropped rather than clamped.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ident_q    <= 8'h00;
			hop_q      <= 8'h00;
			tx_level_q <= 8'h00;
			baud_q     <= 8'h00;
			role_q     <= 8'h00;
			idle_clk_q <= 8'h00;
			ext_addr_q <= EXT_SLP_ADDR_RST;
			rate_q     <= RADIO_RATE_RST;
			tw_cfg_q   <= 8'h00;
			settle_ms_q <= 8'h00;
		end else if (wr_en) begin
			if (paddr == OFF_NETWORK_IDENT && ident_w <= NET_IDENT_MAX)
				ident_q <= ident_w;
			if (paddr == OFF_HOP_SEQ_SEL && hop_w <= HOP_SEQ_MAX)
				hop_q <= hop_w;
			if (paddr == OFF_TX_LEVEL_SEL)
				tx_level_q <= wbyte(tx_level_q, pwdata, wmask);
			if (paddr == OFF_SERIAL_BAUD_SEL)
				baud_q <= wbyte(baud_q, pwdata, wmask);
			if (paddr == OFF_ROLE_SEL)
				role_q <= wbyte(role_q, pwdata, wmask);
			if (paddr == OFF_IDLE_CLOCK_SEL)
				idle_clk_q <= wbyte(idle_clk_q, pwdata, wmask);
			if (paddr == OFF_EXT_SLP_ADDR)
				ext_addr_q <= wbyte(ext_addr_q, pwdata, wmask);
			if (paddr == OFF_RADIO_RATE)
				rate_q <= wbyte(rate_q, pwdata, wmask);
			if (paddr == OFF_TWO_WIRE_CFG)
				tw_cfg_q <= wbyte(tw_cfg_q, pwdata, wmask);
			if (paddr == OFF_AUX_SETTLE_MS)
				settle_ms_q <= wbyte(settle_ms_q, pwdata, wmask);
			// Writes to the timing and drift words fall through untouched.
		end
	end

	// --------------------------------------------------------------------
	// Read-only timing and drift
	// --------------------------------------------------------------------
	// A scheduled timing change waits in a pending slot until the cycle begins.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timing_q      <= 8'h00;
			pend_timing_q <= 8'h00;
			pend_valid_q  <= 1'b0;
			drift_q       <= DRIFT_CORR_RST;
		end else begin
			drift_q <= drift_corr_in;
			if (wr_en && paddr == OFF_PEND_TIMING && timing_sched)
				pend_timing_q <= wbyte(pend_timing_q, pwdata, wmask);
			if (cycle_start && pend_valid_q) begin
				timing_q     <= pend_timing_q;
				pend_valid_q <= 1'b0;
			end
			if (wr_en && paddr == OFF_PEND_TIMING && timing_sched)
				pend_valid_q <= 1'b1;
		end
	end

	// --------------------------------------------------------------------
	// Access key filter
	// --------------------------------------------------------------------
	logic key_match;

	assign key_match = (rx_net_ident == ident_q) && (rx_hop_seq == hop_q) &&
		rx_key_ok;
	assign rx_accept = rx_valid && key_match;

	// Sticky last-packet verdict for software.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_accept_q <= 1'b0;
			rx_drop_q   <= 1'b0;
		end else if (rx_valid) begin
			rx_accept_q <= key_match;
			rx_drop_q   <= !key_match;
		end
	end

	// --------------------------------------------------------------------
	// Configuration outputs
	// --------------------------------------------------------------------
	assign net_timing    = timing_q;
	assign hop_seq       = hop_q;
	assign net_ident     = ident_q;
	assign cipher_key    = key_q;
	assign tx_high_power = tx_level_q[0];
	assign role_node     = role_q[0];
	assign baud_sel      = baud_q;
	assign idle_clk      = idle_clk_q[1:0];
	assign rc_cal_req    = (idle_clk_q[1:0] == CLK_RC) && cycle_start &&
		!rc_cal_done;
	assign ext_ctrl_addr = ext_addr_q;
	assign rate_100k     = rate_q[0];
	assign payload_max   = rate_q[0] ? PAYLOAD_MAX_100K : PAYLOAD_MAX_50K;
	assign bit_period    = tw_cfg_q[TW_BIT_PERIOD_LSB +: 4];
	assign port_sel      = tw_cfg_q[TW_PORT_SEL_BIT];
	assign pullup_en     = tw_cfg_q[TW_PULLUP_BIT];

	// --------------------------------------------------------------------
	// Auxiliary power pin
	// --------------------------------------------------------------------
	mrc_aux_if aux ();

	assign aux.req       = ext_txn_req && (idle_clk_q[1:0] == CLK_EXT);
	assign aux.done      = ext_txn_done;
	assign aux.mode      = tw_cfg_q[TW_AUX_MODE_LSB +: 2];
	assign aux.settle_ms = settle_ms_q;
	assign bus_go        = aux.bus_go;
	assign aux_pin_o     = aux.pin_o;
	assign aux_pin_oe    = aux.pin_oe;

	mrc_aux_seq #(
		.CYC_MS (CYC_MS)
	) u_aux_seq (
		.clk    (clk),
		.arst_n (arst_n),
		.aux    (aux.seq)
	);
endmodule // mrc_config_regs

// File: testbench/mrc_config_regs_asserts.sv
// Concurrent checks on the port behaviour of the configuration register bank.
`timescale 1ns/10ps
module mrc_config_regs_asserts
	import mrc_pkg::*;
(
	// Clock and reset.
	input wire logic        clk,
	input wire logic        arst_n,
	// APB request side.
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	// Radio events and packet header.
	input wire logic        cycle_start,
	input wire logic        rx_valid,
	input wire logic [7:0]  rx_net_ident,
	input wire logic [7:0]  rx_hop_seq,
	input wire logic        rx_key_ok,
	input wire logic        rx_accept,
	// Configuration outputs.
	input wire logic [7:0]  net_timing,
	input wire logic [7:0]  hop_seq,
	input wire logic [7:0]  net_ident,
	input wire logic [1:0]  idle_clk,
	input wire logic        rc_cal_req,
	input wire logic [7:0]  ext_ctrl_addr,
	input wire logic        rate_100k,
	input wire logic [7:0]  payload_max
);
	// ----------------------------------------------------------------
	// Sequences and properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// A completed write access to one address.
	sequence s_wr(a);
		psel && penable && pwrite && paddr == a;
	endsequence

	property p_timing_hold;
		$changed(net_timing) |-> $past(cycle_start);
	endproperty
	property p_ident_range;
		net_ident <= NET_IDENT_MAX;
	endproperty
	property p_ident_wr;
		s_wr(OFF_NETWORK_IDENT) ##0 (pwdata[7:0] <= NET_IDENT_MAX) |=> net_ident == $past(pwdata[7:0]);
	endproperty
	property p_hop_range;
		hop_seq <= HOP_SEQ_MAX;
	endproperty
	property p_hop_rej;
		s_wr(OFF_HOP_SEQ_SEL) ##0 (pwdata[7:0] > HOP_SEQ_MAX) |=> $stable(hop_seq);
	endproperty
	property p_accept;
		rx_accept |-> rx_valid && rx_key_ok && rx_net_ident == net_ident && rx_hop_seq == hop_seq;
	endproperty
	property p_match;
		rx_valid && rx_key_ok && rx_net_ident == net_ident && rx_hop_seq == hop_seq |-> rx_accept;
	endproperty
	property p_rc_cal;
		rc_cal_req |-> cycle_start && idle_clk == CLK_RC;
	endproperty
	property p_ext_rst;
		$rose(arst_n) |-> ext_ctrl_addr == EXT_SLP_ADDR_RST;
	endproperty
	property p_payload;
		payload_max == (rate_100k ? PAYLOAD_MAX_100K : PAYLOAD_MAX_50K);
	endproperty

	a_timing_hold: assert property (p_timing_hold) else $error("timing changed without cycle start");
	a_ident_range: assert property (p_ident_range) else $error("network ident out of range");
	a_ident_wr: assert property (p_ident_wr) else $error("legal ident write lost");
	a_hop_range: assert property (p_hop_range) else $error("hop selector out of range");
	a_hop_rej: assert property (p_hop_rej) else $error("illegal hop write taken");
	a_accept: assert property (p_accept) else $error("foreign packet accepted");
	a_match: assert property (p_match) else $error("matching packet dropped");
	a_rc_cal: assert property (p_rc_cal) else $error("calibration outside RC cycle start");
	a_ext_rst: assert property (p_ext_rst) else $error("controller address reset wrong");
	a_payload: assert property (p_payload) else $error("payload limit wrong for rate");
endmodule // mrc_config_regs_asserts

bind mrc_config_regs mrc_config_regs_asserts u_chk (.*);

// File: testbench/tb_top.sv
// Self-checking bench of the configuration register bank.
`timescale 1ns/10ps
module tb_top
	import mrc_pkg::*;
;
	// ----------------------------------------------------------------
	// Signals and model
	// ----------------------------------------------------------------
	logic clk, arst_n, psel, penable, pwrite, cycle_start, timing_sched, rc_cal_done;
	logic rx_valid, rx_key_ok, ext_txn_req, ext_txn_done, pready, pslverr, rx_accept;
	logic tx_high_power, role_node, rc_cal_req, rate_100k, port_sel, pullup_en;
	logic bus_go, aux_pin_o, aux_pin_oe;
	logic [7:0] paddr, drift_corr_in, rx_net_ident, rx_hop_seq, net_timing, hop_seq;
	logic [7:0] net_ident, baud_sel, ext_ctrl_addr, payload_max;
	logic [31:0] pwdata, prdata, lf;
	logic [3:0] pstrb, bit_period;
	logic [1:0] idle_clk;
	logic [63:0] eff_addr;
	logic [127:0] cipher_key;
	logic [31:0] mdl [logic [7:0]];
	int mismatches = 0;
	int checked = 0;

	// Settle value of four cycles per millisecond keeps the delay short.
	mrc_config_regs #(.CYC_MS(4)) dut (.*);

	// Free-running 200 MHz clock.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] rnd();
		lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
		return lf;
	endfunction

	function automatic logic [31:0] msk(input logic [7:0] a);
		return (a == 8'h08 || a == 8'h0C || (a >= 8'h38 && a <= 8'h44)) ? 32'hFFFFFFFF : 32'hFF;
	endfunction

	// Writes the model takes; rejected values leave a register alone.
	function automatic bit legal(input logic [7:0] a, input logic [31:0] d);
		case (a)
			OFF_NET_TIMING, OFF_EXT_SLP_DRIFT: return 1'b0;
			OFF_NETWORK_IDENT: return d <= NET_IDENT_MAX;
			OFF_HOP_SEQ_SEL: return d <= HOP_SEQ_MAX;
			OFF_ADDR_BYTE_COUNT: return d <= ADDR_BYTES_MAX;
			OFF_PEND_TIMING: return timing_sched;
			default: return a < OFF_PEND_TIMING;
		endcase
	endfunction

	function automatic logic [63:0] eff();
		logic [63:0] v;
		v = {mdl[8'h0C], mdl[8'h08]};
		for (int i = 0; i < 8; i++) if (i >= mdl[8'h04]) v[i*8 +: 8] = 8'h00;
		return v;
	endfunction

	task automatic chk(input string nm, input logic [127:0] got, input logic [127:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic tally_and_finish();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// One APB transfer; ends at the falling edge so outputs have settled.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] rd, output logic er);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			mismatches++;
			tally_and_finish();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
		if (legal(a, d)) mdl[a] = d & msk(a);
	endtask

	// Reads back every mapped register except the status word and checks the outputs.
	task automatic all_regs();
		logic [31:0] r;
		logic e;
		for (int a = 4; a <= 8'h50; a += 4) begin
			apb(1'b0, a[7:0], 32'h0, r, e);
			chk("prdata", r, mdl[a[7:0]]);
		end
		chk("eff_addr", eff_addr, eff());
		chk("cipher_key", cipher_key,
			{mdl[8'h44], mdl[8'h40], mdl[8'h3C], mdl[8'h38]});
		chk("net_ident", net_ident, mdl[8'h14]);
		chk("hop_seq", hop_seq, mdl[8'h18]);
		chk("tx_high_power", tx_high_power, mdl[8'h1C][0]);
		chk("role_node", role_node, mdl[8'h24][0]);
		chk("baud_sel", baud_sel, mdl[8'h20]);
		chk("ext_ctrl_addr", ext_ctrl_addr, mdl[8'h2C]);
		chk("rate_100k", rate_100k, mdl[8'h34][0]);
		chk("payload_max", payload_max, mdl[8'h34][0] ? 8'h48 : 8'h14);
	endtask

	// Broadcast cycle start; the pending timing word lands here.
	task automatic cyc();
		@(posedge clk);
		cycle_start <= 1'b1;
		@(negedge clk);
		chk("rc_cal_req", rc_cal_req, mdl[8'h28] == 1 && !rc_cal_done);
		@(posedge clk);
		cycle_start <= 1'b0;
		mdl[8'h10] = mdl[8'h50];
		@(negedge clk);
		chk("net_timing", net_timing, mdl[8'h10]);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [31:0] r;
		logic e;
		int n;
		lf = 32'd39;
		{psel, penable, pwrite, cycle_start, timing_sched, rc_cal_done} = '0;
		{rx_valid, rx_key_ok, ext_txn_req, ext_txn_done, arst_n} = '0;
		{paddr, pwdata, rx_net_ident, rx_hop_seq} = '0;
		pstrb = 4'hF;
		drift_corr_in = 8'(rnd());
		for (int a = 0; a <= 8'h54; a += 4) mdl[a[7:0]] = 32'h0;
		mdl[8'h04] = 32'h8;
		mdl[8'h2C] = 32'h48;
		mdl[8'h30] = drift_corr_in;
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		all_regs();
		foreach (mdl[a]) if (a != 8'h04 && a < 8'h50) wr(a, rnd() & msk(a));
		foreach (mdl[a]) if (a == 8'h04 || a == 8'h14 || a == 8'h18) wr(a, 32'h8 - (a >> 3));
		all_regs();
		wr(OFF_NETWORK_IDENT, 32'h7);
		wr(OFF_HOP_SEQ_SEL, 32'h6);
		wr(OFF_ADDR_BYTE_COUNT, 32'h3);
		wr(OFF_RADIO_RATE, 32'h1);
		apb(1'b1, 8'h60, rnd(), r, e);
		chk("pslverr", e, 1'b1);
		all_regs();
		// Pending timing only counts while the schedule command is active.
		wr(OFF_PEND_TIMING, 32'h5A);
		@(posedge clk);
		timing_sched <= 1'b1;
		wr(OFF_PEND_TIMING, 32'h3C);
		chk("net_timing", net_timing, mdl[8'h10]);
		@(posedge clk);
		timing_sched <= 1'b0;
		// RC mode is only visited for one short cycle, well inside two seconds.
		for (int m = 0; m < 3; m++) begin
			wr(OFF_IDLE_CLOCK_SEL, m);
			chk("idle_clk", idle_clk, m);
			@(posedge clk);
			rc_cal_done <= !m[0];
			cyc();
		end
		for (int i = 0; i < 24; i++) begin
			r = rnd();
			@(posedge clk);
			rx_valid <= 1'b1;
			rx_net_ident <= r[0] ? mdl[8'h14][7:0] : {5'h0, r[6:4]};
			rx_hop_seq <= r[1] ? mdl[8'h18][7:0] : {5'h0, r[10:8]};
			rx_key_ok <= r[2];
			@(negedge clk);
			chk("rx_accept", rx_accept,
				rx_net_ident == mdl[8'h14] && rx_hop_seq == mdl[8'h18] && rx_key_ok);
		end
		@(posedge clk);
		rx_valid <= 1'b0;
		wr(OFF_IDLE_CLOCK_SEL, 32'h2);
		wr(OFF_AUX_SETTLE_MS, 32'h2);
		for (int m = 0; m < 4; m++) begin
			wr(OFF_TWO_WIRE_CFG, (m << 6) | 32'h2A);
			chk("tw_cfg", {bit_period, port_sel, pullup_en}, 6'h29);
			@(posedge clk);
			ext_txn_req <= 1'b1;
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while (bus_go !== 1'b1 && n < 40);
			if (n >= 40) begin
				mismatches++;
				tally_and_finish();
			end
			chk("bus_go_wait", m == 1 ? (n >= 8 && n <= 12) : n == 1, 1'b1);
			chk("aux_pin", {aux_pin_oe, aux_pin_o & aux_pin_oe},
				m == 0 ? 2'b00 : m == 2 ? 2'b10 : 2'b11);
			@(posedge clk);
			ext_txn_done <= 1'b1;
			ext_txn_req <= 1'b0;
			@(posedge clk);
			ext_txn_done <= 1'b0;
			@(negedge clk);
			chk("aux_oe_after", aux_pin_oe, m >= 2);
		end
		tally_and_finish();
	end
endmodule // tb_top
